// [hdl/bce_pkg.sv]
package bce_pkg;

    // -----------------------------------------------------------------
    // Register offsets (byte addresses, one word each)
    // -----------------------------------------------------------------
    localparam logic [7:0] TAG_STS_OFF   = 8'h00;
    localparam logic [7:0] TAG_IDX_OFF   = 8'h04;
    localparam logic [7:0] TAG_RAW_OFF   = 8'h08;
    localparam logic [7:0] DAT_STS_OFF   = 8'h0C;
    localparam logic [7:0] DAT_IDX_OFF   = 8'h10;
    localparam logic [7:0] DAT_SYN_OFF   = 8'h14;
    localparam logic [7:0] CTL_OFF       = 8'h18;
    localparam logic [7:0] FLUSH_OFF     = 8'h1C;
    localparam logic [7:0] TAGW_IDX_OFF  = 8'h20;
    localparam logic [7:0] TAGW_DAT_OFF  = 8'h24;
    localparam logic [7:0] IRQ_STS_OFF   = 8'h28;
    localparam logic [7:0] IRQ_CLR_OFF   = 8'h2C;
    localparam logic [7:0] IRQ_EN_OFF    = 8'h30;

    // -----------------------------------------------------------------
    // Status field positions (shared by tag and data status words) and the control word mode bit
    // -----------------------------------------------------------------
    localparam int ST_LOCK   = 0;
    localparam int ST_CORR   = 1;
    localparam int ST_UNCORR = 2;
    localparam int ST_BADADR = 3;
    localparam int ST_LOST   = 4;
    localparam int ST_CMD_LO = 8;
    localparam int CTL_ETM   = 0;

    // Interrupt status bit positions.
    localparam int IRQ_TAG_UNC = 0;
    localparam int IRQ_TAG_COR = 1;
    localparam int IRQ_DAT_UNC = 2;
    localparam int IRQ_DAT_COR = 3;
    localparam int IRQ_N       = 4;

    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [3:0]  RST_NIB  = 4'h0;

    // -----------------------------------------------------------------
    // Widths
    // -----------------------------------------------------------------
    localparam int AW  = 32;
    localparam int IW  = 16;
    localparam int TW  = 32;
    localparam int SW  = 8;

    typedef enum logic [3:0] {
        BCE_CMD_IREAD   = 4'h3,
        BCE_CMD_DREAD   = 4'h7,
        BCE_CMD_OREAD   = 4'h6,
        BCE_CMD_WUNLOCK = 4'h9,
        BCE_CMD_RINVAL  = 4'hA,
        BCE_CMD_OINVAL  = 4'hB,
        BCE_CMD_DEALLOC = 4'hC
    } bce_cmd_t;

    typedef struct packed {
        logic          valid;
        logic          corr;
        logic          uncorr;
        logic          bad_addr;
        logic [AW-1:0] paddr;
        logic [TW-1:0] raw_tag;
        logic [3:0]    cmd;
    } bce_tag_ev_t;

    typedef struct packed {
        logic          valid;
        logic          corr;
        logic          uncorr;
        logic          bad_addr;
        logic          hit_read;
        logic [IW-1:0] index;
        logic [SW-1:0] syndrome;
        logic [3:0]    cmd;
    } bce_dat_ev_t;

    typedef struct packed {
        logic          valid;
        logic          write;
        logic [7:0]    addr;
        logic [31:0]   wdata;
    } bce_bus_t;

endpackage : bce_pkg

// [hdl/bce_capture.sv]
`timescale 1ns/10ps

// Notes on behaviour
// - Uncorrectable tag error while one is held sets lost flag, keeps report.
// - Every uncorrectable tag error, latched or lost, raises the soft interrupt.
// - Correctable tag error stays in normal mode and captures the failing address.
// - Captured tag address carries the cache index bits.
// - Tag error latches raw tag and check bits as read.
// - Correctable tag error under held uncorrectable report sets only its flag.
// - Data error captures cache index and computed syndrome.
// - Correctable data error never enters error transition mode.
// - Correctable data error under held uncorrectable report sets only its flag.
// - Read address disagreeing with write address flags an addressing error.
// - Data addressing mismatch plus single-bit error reports as uncorrectable.
// - Uncorrectable or addressing error on read hit enters error transition mode.
// - Addressing and uncorrectable flags never set together for one event.
// - Flush write pulses flush_req for one cycle with the written index, no transition mode.
// - Tag access path writes any tag value into any entry.
// - Write unlock with tag error in transition mode is still forwarded.
module bce_capture (
    input  wire logic               core_clk,
    input  wire logic               resetn,
    input  wire bce_pkg::bce_bus_t  bus,
    output logic [31:0]             rdata,
    input  wire bce_pkg::bce_tag_ev_t tag_ev,
    input  wire bce_pkg::bce_dat_ev_t dat_ev,
    input  wire logic               wunlock_req,
    output logic                    wunlock_fwd,
    output logic                    etm,
    output logic                    flush_req,
    output logic [bce_pkg::IW-1:0]  flush_index,
    output logic                    tag_wr,
    output logic [bce_pkg::IW-1:0]  tag_wr_index,
    output logic [bce_pkg::TW-1:0]  tag_wr_data,
    output logic                    irq
);
    import bce_pkg::*;

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [31:0]      rdata;
        logic             t_lock;
        logic             t_corr;
        logic             t_unc;
        logic             t_bad;
        logic             t_lost;
        logic [3:0]       t_cmd;
        logic [AW-1:0]    t_idx;
        logic [TW-1:0]    t_raw;
        logic             d_lock;
        logic             d_corr;
        logic             d_unc;
        logic             d_bad;
        logic             d_lost;
        logic [3:0]       d_cmd;
        logic [IW-1:0]    d_idx;
        logic [SW-1:0]    d_syn;
        logic             etm;
        logic             flush;
        logic [IW-1:0]    flush_idx;
        logic             tag_wr;
        logic [IW-1:0]    tw_idx;
        logic [TW-1:0]    tw_dat;
        logic [IRQ_N-1:0] irq_sts;
        logic [IRQ_N-1:0] irq_en;
    } bce_state_t;

    bce_state_t st_ff;
    bce_state_t nxt_st;

    logic wr;
    logic rd;
    logic [31:0] wd;
    logic t_unc_ev;
    logic d_unc_ev;
    logic d_bad_ev;
    logic [IRQ_N-1:0] irq_ev;

    assign wr = bus.valid & bus.write;
    assign rd = bus.valid & ~bus.write;
    assign wd = bus.wdata;

    // An addressing error with a single-bit data error counts as uncorrectable.
    assign d_unc_ev = dat_ev.valid & (dat_ev.uncorr | (dat_ev.bad_addr & dat_ev.corr));
    assign d_bad_ev = dat_ev.valid & dat_ev.bad_addr & ~dat_ev.corr & ~dat_ev.uncorr;
    assign t_unc_ev = tag_ev.valid & (tag_ev.uncorr | tag_ev.bad_addr);
    assign irq_ev   = {dat_ev.valid & dat_ev.corr & ~dat_ev.bad_addr & ~dat_ev.uncorr,
                       d_unc_ev | d_bad_ev,
                       tag_ev.valid & tag_ev.corr & ~t_unc_ev,
                       t_unc_ev};

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.flush  = 1'b0;
        nxt_st.tag_wr = 1'b0;
        nxt_st.rdata  = RST_WORD;

        // Software clears come first so that a same-cycle event wins.
        if (wr) begin
            case (bus.addr)
                TAG_STS_OFF: begin
                    if (wd[ST_LOCK])   nxt_st.t_lock = 1'b0;
                    if (wd[ST_CORR])   nxt_st.t_corr = 1'b0;
                    if (wd[ST_UNCORR]) nxt_st.t_unc  = 1'b0;
                    if (wd[ST_BADADR]) nxt_st.t_bad  = 1'b0;
                    if (wd[ST_LOST])   nxt_st.t_lost = 1'b0;
                end
                DAT_STS_OFF: begin
                    if (wd[ST_LOCK])   nxt_st.d_lock = 1'b0;
                    if (wd[ST_CORR])   nxt_st.d_corr = 1'b0;
                    if (wd[ST_UNCORR]) nxt_st.d_unc  = 1'b0;
                    if (wd[ST_BADADR]) nxt_st.d_bad  = 1'b0;
                    if (wd[ST_LOST])   nxt_st.d_lost = 1'b0;
                end
                CTL_OFF:      nxt_st.etm = wd[CTL_ETM];
                FLUSH_OFF: begin
                    nxt_st.flush     = 1'b1;
                    nxt_st.flush_idx = wd[IW-1:0];
                end
                TAGW_IDX_OFF: nxt_st.tw_idx = wd[IW-1:0];
                TAGW_DAT_OFF: begin
                    nxt_st.tw_dat = wd[TW-1:0];
                    nxt_st.tag_wr = 1'b1;
                end
                IRQ_CLR_OFF:  nxt_st.irq_sts = st_ff.irq_sts & ~wd[IRQ_N-1:0];
                IRQ_EN_OFF:   nxt_st.irq_en  = wd[IRQ_N-1:0];
                default: ;
            endcase
        end

        // Tag store errors.
        if (t_unc_ev) begin
            if (st_ff.t_lock) begin
                nxt_st.t_lost = 1'b1;
            end else begin
                nxt_st.t_lock = 1'b1;
                nxt_st.t_unc  = tag_ev.uncorr & ~tag_ev.bad_addr;
                nxt_st.t_bad  = tag_ev.bad_addr;
                nxt_st.t_idx  = tag_ev.paddr;
                nxt_st.t_raw  = tag_ev.raw_tag;
                nxt_st.t_cmd  = tag_ev.cmd;
            end
            nxt_st.etm = 1'b1;
        end else if (tag_ev.valid && tag_ev.corr) begin
            nxt_st.t_corr = 1'b1;
            if (!st_ff.t_lock) begin
                nxt_st.t_idx = tag_ev.paddr;
                nxt_st.t_raw = tag_ev.raw_tag;
                nxt_st.t_cmd = tag_ev.cmd;
            end
        end

        // Data RAM errors.
        if (d_unc_ev || d_bad_ev) begin
            if (st_ff.d_lock) begin
                nxt_st.d_lost = 1'b1;
            end else begin
                nxt_st.d_lock = 1'b1;
                nxt_st.d_unc  = d_unc_ev;
                nxt_st.d_bad  = d_bad_ev;
                nxt_st.d_idx  = dat_ev.index;
                nxt_st.d_syn  = dat_ev.syndrome;
                nxt_st.d_cmd  = dat_ev.cmd;
            end
            if (dat_ev.hit_read) nxt_st.etm = 1'b1;
        end else if (dat_ev.valid && dat_ev.corr) begin
            nxt_st.d_corr = 1'b1;
            if (!st_ff.d_lock) begin
                nxt_st.d_idx = dat_ev.index;
                nxt_st.d_syn = dat_ev.syndrome;
                nxt_st.d_cmd = dat_ev.cmd;
            end
        end

        nxt_st.irq_sts = nxt_st.irq_sts | irq_ev;

        if (rd) begin
            case (bus.addr)
                TAG_STS_OFF: nxt_st.rdata = {20'h0_0000, st_ff.t_cmd, 3'h0, st_ff.t_lost,
                                             st_ff.t_bad, st_ff.t_unc, st_ff.t_corr,
                                             st_ff.t_lock};
                TAG_IDX_OFF: nxt_st.rdata = st_ff.t_idx;
                TAG_RAW_OFF: nxt_st.rdata = st_ff.t_raw;
                DAT_STS_OFF: nxt_st.rdata = {20'h0_0000, st_ff.d_cmd, 3'h0, st_ff.d_lost,
                                             st_ff.d_bad, st_ff.d_unc, st_ff.d_corr,
                                             st_ff.d_lock};
                DAT_IDX_OFF: nxt_st.rdata = {16'h0000, st_ff.d_idx};
                DAT_SYN_OFF: nxt_st.rdata = {24'h00_0000, st_ff.d_syn};
                CTL_OFF:     nxt_st.rdata = {31'h0000_0000, st_ff.etm};
                IRQ_STS_OFF: nxt_st.rdata = {28'h000_0000, st_ff.irq_sts};
                IRQ_EN_OFF:  nxt_st.rdata = {28'h000_0000, st_ff.irq_en};
                default:     nxt_st.rdata = RST_WORD;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    assign rdata        = st_ff.rdata;
    assign etm          = st_ff.etm;
    assign flush_req    = st_ff.flush;
    assign flush_index  = st_ff.flush_idx;
    assign tag_wr       = st_ff.tag_wr;
    assign tag_wr_index = st_ff.tw_idx;
    assign tag_wr_data  = st_ff.tw_dat;
    assign irq          = |(st_ff.irq_sts & st_ff.irq_en);
    // In transition mode a write unlock is looked up but always reaches memory.
    assign wunlock_fwd  = wunlock_req;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    a_lost_tag_set: assert property (@(posedge core_clk) disable iff (!resetn)
        (t_unc_ev && st_ff.t_lock) |=> (st_ff.t_lost && st_ff.t_idx == $past(st_ff.t_idx)))
        else $error("Lost tag error not flagged.");

    a_tag_unc_irq: assert property (@(posedge core_clk) disable iff (!resetn)
        t_unc_ev |=> st_ff.irq_sts[IRQ_TAG_UNC])
        else $error("Tag uncorrectable did not set interrupt status.");

    a_tag_corr_cap: assert property (@(posedge core_clk) disable iff (!resetn)
        (tag_ev.valid && tag_ev.corr && !t_unc_ev && !st_ff.t_lock)
        |=> (st_ff.t_idx == $past(tag_ev.paddr) && st_ff.t_raw == $past(tag_ev.raw_tag)))
        else $error("Correctable tag capture wrong.");

    a_dat_corr_keep: assert property (@(posedge core_clk) disable iff (!resetn)
        (dat_ev.valid && dat_ev.corr && !d_unc_ev && !d_bad_ev && st_ff.d_lock)
        |=> (st_ff.d_corr && st_ff.d_syn == $past(st_ff.d_syn)))
        else $error("Correctable data error overwrote held report.");

    a_dat_etm_enter: assert property (@(posedge core_clk) disable iff (!resetn)
        ((d_unc_ev || d_bad_ev) && dat_ev.hit_read) |=> st_ff.etm)
        else $error("Read hit data error did not enter transition mode.");

    a_dat_flags_excl: assert property (@(posedge core_clk) disable iff (!resetn)
        !(st_ff.d_bad && st_ff.d_unc))
        else $error("Addressing and uncorrectable both set.");

    a_flush_pulse: assert property (@(posedge core_clk) disable iff (!resetn)
        (wr && bus.addr == FLUSH_OFF) |=> (flush_req && flush_index == $past(wd[IW-1:0]))
        ##1 !flush_req)
        else $error("Flush request not a single pulse.");

    a_tag_write: assert property (@(posedge core_clk) disable iff (!resetn)
        (wr && bus.addr == TAGW_DAT_OFF) |=> (tag_wr && tag_wr_data == $past(wd)))
        else $error("Tag write not issued.");

    a_addr_mix_unc: assert property (@(posedge core_clk) disable iff (!resetn)
        (dat_ev.valid && dat_ev.bad_addr && dat_ev.corr && !st_ff.d_lock)
        |=> (st_ff.d_unc && !st_ff.d_bad))
        else $error("Mixed error not reported as uncorrectable.");

    // -----------------------------------------------------------------
    // Capture sequences
    // -----------------------------------------------------------------
    // A software write to the control word may legally move the mode bit,
    // so the mode checks below only look at cycles without one.
    sequence s_ctl_quiet;
        !(wr && bus.addr == CTL_OFF);
    endsequence

    sequence s_tag_unc_new;
        t_unc_ev && !st_ff.t_lock;
    endsequence

    sequence s_tag_corr_held;
        tag_ev.valid && tag_ev.corr && !t_unc_ev && st_ff.t_lock;
    endsequence

    sequence s_dat_err_new;
        (d_unc_ev || d_bad_ev) && !st_ff.d_lock;
    endsequence

    sequence s_dat_corr_only;
        dat_ev.valid && dat_ev.corr && !d_unc_ev && !d_bad_ev;
    endsequence

    sequence s_no_hard_ev;
        !t_unc_ev && !d_unc_ev && !d_bad_ev;
    endsequence

    a_tag_raw_cap: assert property (@(posedge core_clk) disable iff (!resetn)
        s_tag_unc_new
        |=> (st_ff.t_raw == $past(tag_ev.raw_tag) && st_ff.t_idx == $past(tag_ev.paddr)))
        else $error("Tag error data not captured as read.");

    a_tag_cmd_cap: assert property (@(posedge core_clk) disable iff (!resetn)
        s_tag_unc_new |=> (st_ff.t_cmd == $past(tag_ev.cmd)))
        else $error("Tag failing command not recorded.");

    a_tag_corr_lost: assert property (@(posedge core_clk) disable iff (!resetn)
        s_tag_corr_held
        |=> (st_ff.t_corr && st_ff.t_idx == $past(st_ff.t_idx)
             && st_ff.t_raw == $past(st_ff.t_raw)))
        else $error("Correctable tag error under held report captured data.");

    a_tag_corr_mode: assert property (@(posedge core_clk) disable iff (!resetn)
        (tag_ev.valid && tag_ev.corr) and s_no_hard_ev and s_ctl_quiet
        |=> (st_ff.etm == $past(st_ff.etm)))
        else $error("Correctable tag error changed transition mode.");

    a_dat_err_cap: assert property (@(posedge core_clk) disable iff (!resetn)
        s_dat_err_new
        |=> (st_ff.d_idx == $past(dat_ev.index) && st_ff.d_syn == $past(dat_ev.syndrome)))
        else $error("Data error index or syndrome not captured.");

    a_dat_corr_mode: assert property (@(posedge core_clk) disable iff (!resetn)
        s_dat_corr_only and s_no_hard_ev and s_ctl_quiet
        |=> (st_ff.etm == $past(st_ff.etm)))
        else $error("Correctable data error changed transition mode.");

    a_dat_bad_flag: assert property (@(posedge core_clk) disable iff (!resetn)
        (d_bad_ev && !st_ff.d_lock) |=> st_ff.d_bad)
        else $error("Addressing error not flagged.");

    a_wunlock_pass: assert property (@(posedge core_clk) disable iff (!resetn)
        (wunlock_req && etm) |-> wunlock_fwd)
        else $error("Write unlock in transition mode not forwarded.");

    // Lock and lost flags only fall on a write to their own status word; anything else
    // dropping them would hide an error from recovery software.
    a_tag_lock_hold: assert property (@(posedge core_clk) disable iff (!resetn)
        (st_ff.t_lock && !(wr && bus.addr == TAG_STS_OFF)) |=> st_ff.t_lock)
        else $error("Tag lock flag dropped without a clear.");

    a_tag_lost_hold: assert property (@(posedge core_clk) disable iff (!resetn)
        (st_ff.t_lost && !(wr && bus.addr == TAG_STS_OFF)) |=> st_ff.t_lost)
        else $error("Tag lost flag dropped without a clear.");

    a_dat_lock_hold: assert property (@(posedge core_clk) disable iff (!resetn)
        (st_ff.d_lock && !(wr && bus.addr == DAT_STS_OFF)) |=> st_ff.d_lock)
        else $error("Data lock flag dropped without a clear.");

    a_dat_cmd_cap: assert property (@(posedge core_clk) disable iff (!resetn)
        s_dat_err_new |=> (st_ff.d_cmd == $past(dat_ev.cmd)))
        else $error("Data failing command not recorded.");

endmodule : bce_capture

// [tb/bce_ram_model.sv]
`timescale 1ns/10ps

// ---------------------------------------------------------------
// Cache RAM stand-in
// ---------------------------------------------------------------
module bce_ram_model (
    input wire logic                   core_clk,
    input wire logic                   resetn,
    input wire logic                   flush_req,
    input wire logic [bce_pkg::IW-1:0] flush_index,
    input wire logic                   tag_wr,
    input wire logic [bce_pkg::IW-1:0] tag_wr_index,
    input wire logic [bce_pkg::TW-1:0] tag_wr_data
);
    import bce_pkg::*;

    // Only sixteen entries are kept, so upper index bits alias.
    logic [TW-1:0] tags_ff [16];
    int            flush_cnt_ff;
    logic [IW-1:0] last_flush_ff;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            flush_cnt_ff  <= 0;
            last_flush_ff <= '0;
        end else begin
            if (tag_wr) begin
                tags_ff[tag_wr_index[3:0]] <= tag_wr_data;
            end
            if (flush_req) begin
                flush_cnt_ff  <= flush_cnt_ff + 1;
                last_flush_ff <= flush_index;
            end
        end
    end
endmodule : bce_ram_model

// [tb/backup_cache_ecc_error_capture_bench.sv]
`timescale 1ns/10ps

module backup_cache_ecc_error_capture_bench;
    import bce_pkg::*;

    logic          core_clk    = 1'b0;
    logic          resetn      = 1'b0;
    bce_bus_t      bus         = '0;
    bce_tag_ev_t   tag_ev      = '0;
    bce_dat_ev_t   dat_ev      = '0;
    logic          wunlock_req = 1'b0;
    logic [31:0]   rdata;
    logic          wunlock_fwd;
    logic          etm;
    logic          flush_req;
    logic          tag_wr;
    logic          irq;
    logic [IW-1:0] flush_index;
    logic [IW-1:0] tag_wr_index;
    logic [TW-1:0] tag_wr_data;
    logic [31:0]   d;
    int            mismatches = 0;
    int            n_checks   = 0;
    localparam bce_cmd_t CMDS [7] = '{BCE_CMD_IREAD, BCE_CMD_DREAD, BCE_CMD_OREAD,
        BCE_CMD_WUNLOCK, BCE_CMD_RINVAL, BCE_CMD_OINVAL, BCE_CMD_DEALLOC};

    bce_capture i_bce_capture (.core_clk(core_clk), .resetn(resetn), .bus(bus),
        .rdata(rdata), .tag_ev(tag_ev), .dat_ev(dat_ev), .wunlock_req(wunlock_req),
        .wunlock_fwd(wunlock_fwd), .etm(etm), .flush_req(flush_req),
        .flush_index(flush_index), .tag_wr(tag_wr), .tag_wr_index(tag_wr_index),
        .tag_wr_data(tag_wr_data), .irq(irq));

    bce_ram_model i_bce_ram_model (.core_clk(core_clk), .resetn(resetn),
        .flush_req(flush_req), .flush_index(flush_index), .tag_wr(tag_wr),
        .tag_wr_index(tag_wr_index), .tag_wr_data(tag_wr_data));

    always #2.5 core_clk = ~core_clk;

    // ---------------------------------------------------------------
    // Access tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        bus <= '{1'b1, 1'b1, a, v};
        @(posedge core_clk);
        bus.valid <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample then.
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        bus <= '{1'b1, 1'b0, a, 32'h0000_0000};
        @(posedge core_clk);
        bus.valid <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task automatic tev(input logic c, u, b, input logic [31:0] pa, rw,
                       input logic [3:0] cm);
        @(posedge core_clk);
        tag_ev <= '{1'b1, c, u, b, pa, rw, cm};
        @(posedge core_clk);
        tag_ev.valid <= 1'b0;
        #1;
    endtask : tev

    task automatic dev(input logic c, u, b, input logic [15:0] ix,
                       input logic [7:0] sy, input logic [3:0] cm);
        @(posedge core_clk);
        dat_ev <= '{1'b1, c, u, b, 1'b1, ix, sy, cm};
        @(posedge core_clk);
        dat_ev.valid <= 1'b0;
        #1;
    endtask : dev

    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    initial begin
        #50000;
        mismatches++;
        stop_test;
    end

    // ---------------------------------------------------------------
    // Test sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        rd(TAG_STS_OFF); chk(d, RST_WORD);
        rd(CTL_OFF); chk(d, RST_WORD);
        rd(8'h3C); chk(d, RST_WORD);
        wr(IRQ_EN_OFF, 32'h0000_000F);
        tev(1'b1, 1'b0, 1'b0, 32'h0001_2340, 32'hA5C3_0F1E, BCE_CMD_DREAD);
        chk(32'(etm), 32'h0);
        chk(32'(irq), 32'h1);
        rd(TAG_STS_OFF); chk(d, 32'h0000_0702);
        rd(TAG_IDX_OFF); chk(d, 32'h0001_2340);
        rd(TAG_RAW_OFF); chk(d, 32'hA5C3_0F1E);
        rd(IRQ_STS_OFF); chk(d, 32'h0000_0002);
        wr(IRQ_EN_OFF, 32'h0000_0000); #1 chk(32'(irq), 32'h0);
        wr(IRQ_EN_OFF, 32'h0000_000F);
        wr(IRQ_CLR_OFF, 32'h0000_0002); #1 chk(32'(irq), 32'h0);
        wr(FLUSH_OFF, 32'h0000_0234); #1 chk(32'(flush_req), 32'h1);
        chk(32'(flush_index), 32'h0000_0234);
        @(posedge core_clk); #1 chk(32'(flush_req), 32'h0);
        chk(32'(etm), 32'h0);
        chk(32'(i_bce_ram_model.last_flush_ff), 32'h0000_0234);
        wr(TAG_STS_OFF, 32'h0000_0002);
        rd(TAG_STS_OFF); chk(32'(d[4:0]), 32'h0);
        foreach (CMDS[i]) begin
            tev(1'b1, 1'b0, 1'b0, 32'h0000_0100, 32'h0000_0000, CMDS[i]);
            rd(TAG_STS_OFF); chk(32'(d[11:8]), 32'(CMDS[i]));
            wr(TAG_STS_OFF, 32'h0000_0002);
        end
        wr(TAGW_IDX_OFF, 32'h0000_0005);
        wr(TAGW_DAT_OFF, 32'h8000_00AB); #1 chk(32'(tag_wr), 32'h1);
        chk(32'(tag_wr_index), 32'h5);
        chk(tag_wr_data, 32'h8000_00AB);
        @(posedge core_clk); #1 chk(i_bce_ram_model.tags_ff[5], 32'h8000_00AB);
        tev(1'b0, 1'b1, 1'b0, 32'h0005_6780, 32'h1234_5678, BCE_CMD_WUNLOCK);
        chk(32'(etm), 32'h1);
        rd(TAG_STS_OFF); chk(d, 32'h0000_0905);
        @(posedge core_clk); wunlock_req <= 1'b1;
        #1 chk(32'(wunlock_fwd), 32'h1);
        @(posedge core_clk); wunlock_req <= 1'b0;
        wr(IRQ_CLR_OFF, 32'h0000_0003); #1 chk(32'(irq), 32'h0);
        tev(1'b0, 1'b1, 1'b0, 32'h0009_9900, 32'h0000_0000, BCE_CMD_OREAD);
        chk(32'(irq), 32'h1);
        rd(TAG_STS_OFF); chk(d, 32'h0000_0915);
        rd(TAG_IDX_OFF); chk(d, 32'h0005_6780);
        tev(1'b1, 1'b0, 1'b0, 32'h000A_BC00, 32'hFFFF_0000, BCE_CMD_IREAD);
        rd(TAG_STS_OFF); chk(32'(d[4:0]), 32'h17);
        rd(TAG_RAW_OFF); chk(d, 32'h1234_5678);
        // Errors are cleared before the flush, and only then the mode bit.
        wr(TAG_STS_OFF, 32'h0000_001F);
        wr(IRQ_CLR_OFF, 32'h0000_000F);
        wr(FLUSH_OFF, 32'h0000_0000);
        wr(CTL_OFF, 32'h0000_0000); #1 chk(32'(etm), 32'h0);
        chk(32'(irq), 32'h0);
        rd(TAG_STS_OFF); chk(32'(d[4:0]), 32'h0);
        dev(1'b1, 1'b0, 1'b0, 16'h1234, 8'h5A, BCE_CMD_IREAD);
        chk(32'(etm), 32'h0);
        rd(DAT_IDX_OFF); chk(d, 32'h0000_1234);
        rd(DAT_SYN_OFF); chk(d, 32'h0000_005A);
        wr(DAT_STS_OFF, 32'h0000_0002);
        dev(1'b0, 1'b1, 1'b0, 16'h0042, 8'hC3, BCE_CMD_DREAD);
        chk(32'(etm), 32'h1);
        rd(DAT_STS_OFF); chk(d, 32'h0000_0705);
        dev(1'b1, 1'b0, 1'b0, 16'h0099, 8'h11, BCE_CMD_IREAD);
        rd(DAT_IDX_OFF); chk(d, 32'h0000_0042);
        rd(DAT_SYN_OFF); chk(d, 32'h0000_00C3);
        rd(DAT_STS_OFF); chk(32'(d[4:0]), 32'h07);
        rd(IRQ_STS_OFF); chk(32'(d[2]), 32'h1);
        wr(DAT_STS_OFF, 32'h0000_001F);
        wr(CTL_OFF, 32'h0000_0000);
        dev(1'b0, 1'b0, 1'b1, 16'h0077, 8'h00, BCE_CMD_DREAD);
        chk(32'(etm), 32'h1);
        rd(DAT_STS_OFF); chk(32'(d[4:0]), 32'h09);
        wr(DAT_STS_OFF, 32'h0000_001F);
        dev(1'b1, 1'b0, 1'b1, 16'h0078, 8'h01, BCE_CMD_DREAD);
        rd(DAT_STS_OFF); chk(32'(d[4:0]), 32'h05);
        stop_test;
    end
endmodule : backup_cache_ecc_error_capture_bench
